// file: logic/esi_defs.svh
/*
 * Constants of the external memory strobe interface: address map bounds,
 * widths, reset values and strobe timing.
 * Assumes a 250 MHz system clock and 24-bit word addresses from the core.
 */
`ifndef ESI_DEFS_SVH
`define ESI_DEFS_SVH

`define ESI_ADDR_W 24
`define ESI_DATA_W 32
`define ESI_UNIT_W 26
`define ESI_FIFO_DEPTH 16

// primary strobe set: low block and the block above internal RAM
`define ESI_PRI_LO_END 24'h7FFFFF
`define ESI_PRI_HI_BASE 24'h880000
`define ESI_PRI_HI_END 24'h8FFFFF
// secondary strobe set runs to the top of the map
`define ESI_SEC_BASE 24'h900000
// I/O strobe range, 128K words
`define ESI_IO_BASE 24'h810000
`define ESI_IO_END 24'h82FFFF

`define ESI_PINS_IDLE 4'hF
`define ESI_ADDR_RST 24'h000000
`define ESI_DATA_RST 32'h00000000

`define ESI_CLK_PERIOD_NS 4
`define ESI_MEM_STROBE_NS 12
`define ESI_IO_STROBE_NS 40
`define ESI_SYNC_STAGES 2
`define ESI_MEM_STROBE_CYC ((`ESI_MEM_STROBE_NS + `ESI_CLK_PERIOD_NS - 1) / `ESI_CLK_PERIOD_NS)
`define ESI_IO_STROBE_CYC ((`ESI_IO_STROBE_NS + `ESI_CLK_PERIOD_NS - 1) / `ESI_CLK_PERIOD_NS)

`endif

// file: logic/esi_pkg.sv
/*
 * Types of the external memory strobe interface.
 * Assumes esi_defs.svh for all numeric constants.
 */
`include "esi_defs.svh"

package esi_pkg;

   typedef enum logic [1:0] {
      ESI_W8  = 2'b00,
      ESI_W16 = 2'b01,
      ESI_W32 = 2'b10
   } esi_width_e;

   typedef enum logic [1:0] {
      ESI_RG_NONE = 2'b00,
      ESI_RG_PRI  = 2'b01,
      ESI_RG_SEC  = 2'b10,
      ESI_RG_IO   = 2'b11
   } esi_region_e;

   typedef enum logic [1:0] {
      ESI_ST_IDLE   = 2'b00,
      ESI_ST_LOAD   = 2'b01,
      ESI_ST_STROBE = 2'b10,
      ESI_ST_RESP   = 2'b11
   } esi_state_e;

   typedef struct packed {
      logic [`ESI_ADDR_W-1:0] addr;
      logic write;
      logic fetch;
      logic [`ESI_DATA_W-1:0] wdata;
   } esi_req_s;

endpackage : esi_pkg

// file: logic/esi_stream_if.sv
/*
 * Valid/ready word stream between the request queue and the strobe engine.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ns

interface esi_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : esi_stream_if

// file: logic/esi_fifo.sv
/*
 * Request queue: WIDTH x DEPTH, valid/ready on both sides, registered full.
 * Assumes DEPTH is a power of two and one clock domain.
 */
`timescale 1ns/1ns

module esi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   esi_stream_if.snk in_s,
   esi_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic avail_q;
   logic empty_q;

   wire push = in_s.valid && avail_q;
   wire pop = out_s.ready && !empty_q;
   wire [AW:0] cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

   // space and empty are flops so the top can drive ready straight out
   assign in_s.ready = avail_q;
   assign out_s.valid = !empty_q;
   assign out_s.data = mem[rd_q];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_s.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         avail_q <= 1'b1;
         empty_q <= 1'b1;
      end else begin
         wr_q <= wr_q + AW'(push);
         rd_q <= rd_q + AW'(pop);
         cnt_q <= cnt_d;
         avail_q <= (cnt_d != (AW+1)'(DEPTH));
         empty_q <= (cnt_d == '0);
      end
   end
endmodule : esi_fifo

// file: logic/esi_strobe_engine.sv
/*
 * External memory strobe interface: queues core/DMA requests, decodes the
 * address into one strobe group, splits or packs items for the physical
 * width and drives the strobe, address and data pins.
 * Assumes width/size inputs come from same-clock control logic; pins are
 * synchronised here.
 */
`timescale 1ns/1ns
`include "esi_defs.svh"

module esi_strobe_engine
   import esi_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire logic [`ESI_ADDR_W-1:0] REQ_ADDR,
   input wire logic REQ_WRITE,
   input wire logic REQ_FETCH,
   input wire logic [`ESI_DATA_W-1:0] REQ_WDATA,
   output logic RSP_VALID,
   output logic [`ESI_DATA_W-1:0] RSP_RDATA,
   input wire logic [1:0] PRIMARY_WIDTH,
   input wire logic [1:0] PRIMARY_SIZE,
   input wire logic [1:0] SECONDARY_WIDTH,
   input wire logic [1:0] SECONDARY_SIZE,
   input wire logic PROGRAM_WIDTH_SELECT,
   output logic [`ESI_ADDR_W-1:0] MEM_ADDR,
   output logic [3:0] PRIMARY_STROBE_N,
   output logic [3:0] SECONDARY_STROBE_N,
   output logic IO_STROBE_N,
   output logic MEM_WRITE_N,
   input wire logic [`ESI_DATA_W-1:0] MEM_DATA_IN,
   output logic [`ESI_DATA_W-1:0] MEM_DATA_OUT,
   output logic MEM_DATA_OE
);

   localparam int REQ_W = $bits(esi_req_s);
   localparam logic [3:0] MEM_CNT = 4'(`ESI_MEM_STROBE_CYC + `ESI_SYNC_STAGES - 1);
   localparam logic [3:0] IO_CNT = 4'(`ESI_IO_STROBE_CYC + `ESI_SYNC_STAGES - 1);

   esi_stream_if #(.W(REQ_W)) in_s ();
   esi_stream_if #(.W(REQ_W)) q_s ();

   esi_fifo #(
      .WIDTH(REQ_W),
      .DEPTH(`ESI_FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .in_s(in_s),
      .out_s(q_s)
   );

   esi_req_s head;
   assign in_s.valid = REQ_VALID;
   assign in_s.data = {REQ_ADDR, REQ_WRITE, REQ_FETCH, REQ_WDATA};
   assign REQ_READY = in_s.ready;
   assign head = esi_req_s'(q_s.data);

   // pin synchronisers
   logic program_width_select_s1_q;
   logic program_width_select_s2_q;
   logic [`ESI_DATA_W-1:0] din_s1_q;
   logic [`ESI_DATA_W-1:0] din_s2_q;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         program_width_select_s1_q <= 1'b0;
         program_width_select_s2_q <= 1'b0;
         din_s1_q <= `ESI_DATA_RST;
         din_s2_q <= `ESI_DATA_RST;
      end else begin
         program_width_select_s1_q <= PROGRAM_WIDTH_SELECT;
         program_width_select_s2_q <= program_width_select_s1_q;
         din_s1_q <= MEM_DATA_IN;
         din_s2_q <= din_s1_q;
      end
   end

   // transaction state
   esi_state_e state_q;
   esi_region_e region_q;
   logic [`ESI_ADDR_W-1:0] addr_q;
   logic write_q;
   logic [`ESI_DATA_W-1:0] wdata_q;
   logic [1:0] width_q;
   logic [1:0] size_q;
   logic [1:0] beat_q;
   logic [1:0] last_q;
   logic [3:0] cnt_q;
   logic [`ESI_DATA_W-1:0] acc_q;

   wire in_pri = (head.addr <= `ESI_PRI_LO_END) ||
                 ((head.addr >= `ESI_PRI_HI_BASE) && (head.addr <= `ESI_PRI_HI_END));
   wire in_sec = (head.addr >= `ESI_SEC_BASE);
   wire in_io = (head.addr >= `ESI_IO_BASE) && (head.addr <= `ESI_IO_END);
   // everything else stays internal, no strobe
   wire esi_region_e region_d = in_pri ? ESI_RG_PRI :
                                in_sec ? ESI_RG_SEC :
                                in_io ? ESI_RG_IO : ESI_RG_NONE;

   // set physical width; per area, sampled per transfer
   wire [1:0] cfg_w = (region_d == ESI_RG_PRI) ? PRIMARY_WIDTH : SECONDARY_WIDTH;
   wire [1:0] cfg_s = (region_d == ESI_RG_PRI) ? PRIMARY_SIZE : SECONDARY_SIZE;
   // unused code 2'b11 behaves as 32 bits
   wire [1:0] cfg_w_ok = (cfg_w == 2'b11) ? ESI_W32 : cfg_w;
   wire [1:0] cfg_s_ok = (cfg_s == 2'b11) ? ESI_W32 : cfg_s;
   // fetch width from the synchronised select pin
   wire [1:0] fetch_w = program_width_select_s2_q ? ESI_W16 : ESI_W32;
   // I/O strobe is always 32-bit data on 32-bit memory
   wire [1:0] width_d = (region_d == ESI_RG_IO) ? ESI_W32 :
                        head.fetch ? fetch_w : cfg_w_ok;
   // program words are 32 bits, split on 16-bit memory
   wire [1:0] size_d = ((region_d == ESI_RG_IO) || head.fetch) ? ESI_W32 : cfg_s_ok;
   // index of the last beat for items wider than memory
   wire [1:0] last_d = (size_d <= width_d) ? 2'd0 :
                       ((size_d - width_d) == 2'd1) ? 2'd1 : 2'd3;

   // per-beat geometry
   wire wide = (size_q > width_q);
   wire [1:0] up = size_q - width_q;
   wire [1:0] dn = width_q - size_q;
   // narrow items share a physical word, each its own address
   wire [`ESI_UNIT_W-1:0] unit_narrow = `ESI_UNIT_W'({2'b00, addr_q} >> dn);
   // wide items use consecutive external addresses, ascending
   wire [`ESI_UNIT_W-1:0] unit_wide = `ESI_UNIT_W'({2'b00, addr_q} << up) |
                                      `ESI_UNIT_W'(beat_q);
   wire [`ESI_UNIT_W-1:0] unit = wide ? unit_wide : unit_narrow;
   wire [1:0] eff_s = wide ? width_q : size_q;
   wire [1:0] low_mask = (dn == 2'd0) ? 2'b00 : (dn == 2'd1) ? 2'b01 : 2'b11;
   wire [1:0] off = wide ? 2'b00 : 2'((addr_q[1:0] & low_mask) << size_q);
   wire [3:0] item_mask = (eff_s == ESI_W8) ? 4'h1 : (eff_s == ESI_W16) ? 4'h3 : 4'hF;
   // only the lanes the item covers
   wire [3:0] lanes = 4'(item_mask << off);
   wire [5:0] part_sh = 6'({beat_q, 3'b000} << width_q);
   wire [4:0] off_sh = {off, 3'b000};
   wire [`ESI_DATA_W-1:0] beat_wdata = wide ? (wdata_q >> part_sh) : (wdata_q << off_sh);

   // dual pins follow the physical width
   // 8-bit: dual pins are address, enable one idle
   wire [3:0] pins_w8 = {unit[1], unit[0], 1'b1, ~lanes[0]};
   // 16-bit: lane-three pin is address, lane-two idle
   wire [3:0] pins_w16 = {unit[0], 1'b1, ~lanes[1], ~lanes[0]};
   wire [3:0] pins_w32 = ~lanes;
   wire [3:0] pins = (width_q == ESI_W8) ? pins_w8 :
                     (width_q == ESI_W16) ? pins_w16 : pins_w32;
   wire [`ESI_ADDR_W-1:0] addr_out = (width_q == ESI_W8) ? unit[25:2] :
                                     (width_q == ESI_W16) ? unit[24:1] : unit[23:0];

   // read data alignment
   wire [`ESI_DATA_W-1:0] w_mask = (width_q == ESI_W8) ? 32'h000000FF :
                                   (width_q == ESI_W16) ? 32'h0000FFFF : 32'hFFFFFFFF;
   wire [`ESI_DATA_W-1:0] s_mask = (size_q == ESI_W8) ? 32'h000000FF :
                                   (size_q == ESI_W16) ? 32'h0000FFFF : 32'hFFFFFFFF;
   // beats assembled into the word, first beat lowest
   wire [`ESI_DATA_W-1:0] acc_wide = acc_q | ((din_s2_q & w_mask) << part_sh);
   wire [`ESI_DATA_W-1:0] item_narrow = (din_s2_q >> off_sh) & s_mask;
   wire [`ESI_DATA_W-1:0] acc_d = wide ? acc_wide : item_narrow;

   wire strobe_done = (state_q == ESI_ST_STROBE) && (cnt_q == 4'h0);
   wire more_beats = (beat_q != last_q);
   assign q_s.ready = (state_q == ESI_ST_IDLE);

   // sequencing
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= ESI_ST_IDLE;
         region_q <= ESI_RG_NONE;
         addr_q <= `ESI_ADDR_RST;
         write_q <= 1'b0;
         wdata_q <= `ESI_DATA_RST;
         width_q <= ESI_W32;
         size_q <= ESI_W32;
         beat_q <= 2'd0;
         last_q <= 2'd0;
         cnt_q <= 4'h0;
         acc_q <= `ESI_DATA_RST;
      end else begin
         case (state_q)
            ESI_ST_IDLE: begin
               if (q_s.valid) begin
                  region_q <= region_d;
                  addr_q <= head.addr;
                  write_q <= head.write;
                  wdata_q <= head.wdata;
                  width_q <= width_d;
                  size_q <= size_d;
                  last_q <= last_d;
                  beat_q <= 2'd0;
                  acc_q <= `ESI_DATA_RST;
                  // unmapped space answers at once with zero
                  state_q <= (region_d == ESI_RG_NONE) ? ESI_ST_RESP : ESI_ST_LOAD;
               end
            end
            ESI_ST_LOAD: begin
               cnt_q <= (region_q == ESI_RG_IO) ? IO_CNT : MEM_CNT;
               state_q <= ESI_ST_STROBE;
            end
            ESI_ST_STROBE: begin
               if (cnt_q != 4'h0) begin
                  cnt_q <= cnt_q - 4'h1;
               end else begin
                  if (!write_q) begin
                     acc_q <= acc_d;
                  end
                  if (more_beats) begin
                     beat_q <= beat_q + 2'd1;
                     state_q <= ESI_ST_LOAD;
                  end else begin
                     state_q <= ESI_ST_RESP;
                  end
               end
            end
            ESI_ST_RESP: begin
               state_q <= ESI_ST_IDLE;
            end
            default: begin
               state_q <= ESI_ST_IDLE;
            end
         endcase
      end
   end

   // pin drivers
   wire loading = (state_q == ESI_ST_LOAD);

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         MEM_ADDR <= `ESI_ADDR_RST;
         PRIMARY_STROBE_N <= `ESI_PINS_IDLE;
         SECONDARY_STROBE_N <= `ESI_PINS_IDLE;
         IO_STROBE_N <= 1'b1;
         MEM_WRITE_N <= 1'b1;
         MEM_DATA_OUT <= `ESI_DATA_RST;
         MEM_DATA_OE <= 1'b0;
      end else if (loading) begin
         MEM_ADDR <= addr_out;
         // only the addressed set is driven
         PRIMARY_STROBE_N <= (region_q == ESI_RG_PRI) ? pins : `ESI_PINS_IDLE;
         SECONDARY_STROBE_N <= (region_q == ESI_RG_SEC) ? pins : `ESI_PINS_IDLE;
         IO_STROBE_N <= (region_q != ESI_RG_IO);
         MEM_WRITE_N <= !write_q;
         MEM_DATA_OUT <= beat_wdata;
         MEM_DATA_OE <= write_q;
      end else if (strobe_done) begin
         // address stays put so slow parts see a stable hold
         PRIMARY_STROBE_N <= `ESI_PINS_IDLE;
         SECONDARY_STROBE_N <= `ESI_PINS_IDLE;
         IO_STROBE_N <= 1'b1;
         MEM_WRITE_N <= 1'b1;
         MEM_DATA_OE <= 1'b0;
      end
   end

   // answer
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         RSP_VALID <= 1'b0;
         RSP_RDATA <= `ESI_DATA_RST;
      end else begin
         RSP_VALID <= 1'b0;
         if (strobe_done && !more_beats) begin
            RSP_VALID <= 1'b1;
            RSP_RDATA <= write_q ? `ESI_DATA_RST : acc_d;
         end else if ((state_q == ESI_ST_IDLE) && q_s.valid && (region_d == ESI_RG_NONE)) begin
            RSP_VALID <= 1'b1;
            RSP_RDATA <= `ESI_DATA_RST;
         end
      end
   end

endmodule : esi_strobe_engine

// file: verif/esi_mem_model.sv
/*
 * Behavioural static memory on the data pins; the word follows the address.
 * Assumes active-low strobe groups that idle at all ones.
 */
`timescale 1ns/1ns
`include "esi_defs.svh"

module esi_mem_model #(
   parameter int DLY = 2
) (
   input wire logic [`ESI_ADDR_W-1:0] mem_addr,
   input wire logic [3:0] pri_n,
   input wire logic [3:0] sec_n,
   input wire logic io_n,
   output logic [`ESI_DATA_W-1:0] rdata
);
   wire sel = pri_n != 4'hF || sec_n != 4'hF || !io_n;
   // narrow sets put low address bits on the dual pins
   wire [1:0] key = !io_n ? 2'h0 : (pri_n != 4'hF ? pri_n[3:2] : sec_n[3:2]);
   wire [7:0] a = mem_addr[7:0];
   initial rdata = 32'h0;
   // a released bus shows the inverse, never a stale word
   always @(sel or mem_addr or key) begin
      rdata <= #DLY sel ? {a ^ 8'h3C, a ^ 8'hC3, a ^ 8'h5A, a} ^ {4{6'h00, key}} : ~rdata;
   end
endmodule : esi_mem_model

// file: verif/esi_strobe_engine_monitor.sv
/*
 * Checker for the strobe engine, bound to its top ports.
 * Assumes one clock and config inputs held still while a request runs.
 */
`timescale 1ns/1ns
`include "esi_defs.svh"

module esi_strobe_engine_monitor
   import esi_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic RSP_VALID,
   input wire logic [1:0] PRIMARY_WIDTH,
   input wire logic [1:0] SECONDARY_WIDTH,
   input wire logic [`ESI_ADDR_W-1:0] MEM_ADDR,
   input wire logic [3:0] PRIMARY_STROBE_N,
   input wire logic [3:0] SECONDARY_STROBE_N,
   input wire logic IO_STROBE_N,
   input wire logic MEM_WRITE_N,
   input wire logic MEM_DATA_OE
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   wire pa = PRIMARY_STROBE_N != 4'hF;
   wire sa = SECONDARY_STROBE_N != 4'hF;
   wire ia = !IO_STROBE_N;
   chk_one_group: assert property ($onehot0({pa, sa, ia}))
      else $error("two strobe groups active");
   chk_io_slow: assert property ($fell(IO_STROBE_N) |-> !IO_STROBE_N [*8])
      else $error("io strobe too short");
   chk_mem_hold: assert property (($past(PRIMARY_STROBE_N) == 4'hF && pa) |-> pa [*4])
      else $error("primary strobe too short");
   chk_w8_pins: assert property ((PRIMARY_WIDTH == ESI_W8 && pa) |-> PRIMARY_STROBE_N[1])
      else $error("byte enable one used at 8 bits");
   chk_w16_pins: assert property ((SECONDARY_WIDTH == ESI_W16 && sa) |->
      SECONDARY_STROBE_N[2] && SECONDARY_STROBE_N[1:0] != 2'h3)
      else $error("bad pins at 16 bits");
   chk_io_range: assert property (ia |-> MEM_ADDR >= `ESI_IO_BASE && MEM_ADDR <= `ESI_IO_END)
      else $error("io strobe outside its range");
   chk_rsp_idle: assert property (RSP_VALID |-> !pa && !sa && !ia)
      else $error("response while strobe active");
   chk_wr_strobe: assert property (!MEM_WRITE_N |-> (pa || sa || ia) && MEM_DATA_OE)
      else $error("write without strobe or drive");
   cover property ($fell(IO_STROBE_N));
   cover property (PRIMARY_WIDTH == ESI_W8 && pa);
   cover property (sa && !MEM_WRITE_N);
endmodule : esi_strobe_engine_monitor

bind esi_strobe_engine esi_strobe_engine_monitor i_esi_strobe_engine_monitor (.CLK_SYS, .RST_N, .RSP_VALID,
   .PRIMARY_WIDTH, .SECONDARY_WIDTH, .MEM_ADDR, .PRIMARY_STROBE_N, .SECONDARY_STROBE_N, .IO_STROBE_N,
   .MEM_WRITE_N, .MEM_DATA_OE);

// file: verif/esi_strobe_engine_bench.sv
/*
 * Bench for the strobe engine: decode, pin mapping, sizes, fetch, queue.
 * Assumes the memory model on the data pins and the bound checker.
 */
`timescale 1ns/1ns
`include "esi_defs.svh"

module esi_strobe_engine_bench
   import esi_pkg::*;
;
   typedef struct {logic [1:0] g; logic [23:0] a; logic [3:0] p; logic w; logic [31:0] d;} esi_beat_s;
   logic clk_sys = 1'b0;
   logic rst_n, req_valid, req_ready, req_write, req_fetch, rsp_valid, pgm, io_n, wr_n, oe, full;
   logic [23:0] req_addr, mem_addr;
   logic [31:0] req_wdata, rsp_rdata, din, dout, rsp_d;
   logic [1:0] pw, ps, sw, ss;
   logic [3:0] pri_n, sec_n, lp, ls;
   logic li;
   logic [23:0] la;
   esi_beat_s bq[$];
   int miscompares = 0;
   int cmp_count = 0;
   int rsp_n = 0;

   esi_strobe_engine i_esi_strobe_engine (.CLK_SYS(clk_sys), .RST_N(rst_n), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .REQ_ADDR(req_addr), .REQ_WRITE(req_write), .REQ_FETCH(req_fetch),
      .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .PRIMARY_WIDTH(pw),
      .PRIMARY_SIZE(ps), .SECONDARY_WIDTH(sw), .SECONDARY_SIZE(ss), .PROGRAM_WIDTH_SELECT(pgm),
      .MEM_ADDR(mem_addr), .PRIMARY_STROBE_N(pri_n), .SECONDARY_STROBE_N(sec_n), .IO_STROBE_N(io_n),
      .MEM_WRITE_N(wr_n), .MEM_DATA_IN(din), .MEM_DATA_OUT(dout), .MEM_DATA_OE(oe));
   esi_mem_model i_esi_mem_model (.mem_addr(mem_addr), .pri_n(pri_n), .sec_n(sec_n), .io_n(io_n), .rdata(din));

   always #2 clk_sys = ~clk_sys;

   // one record per beat, taken mid-cycle when pins are settled
   always @(negedge clk_sys) begin
      if (rsp_valid === 1'b1) begin
         rsp_n++;
         rsp_d = rsp_rdata;
      end
      if ((pri_n != 4'hF || sec_n != 4'hF || !io_n) && {pri_n, sec_n, io_n, mem_addr} !== {lp, ls, li, la})
         bq.push_back('{!io_n ? ESI_RG_IO : pri_n != 4'hF ? ESI_RG_PRI : ESI_RG_SEC, mem_addr,
            pri_n != 4'hF ? pri_n : sec_n, wr_n, dout & {32{oe}}});
      {lp, ls, li, la} = {pri_n, sec_n, io_n, mem_addr};
   end

   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   function automatic logic [31:0] mw(input logic [23:0] a, input logic [1:0] k);
      mw = {a[7:0] ^ 8'h3C, a[7:0] ^ 8'hC3, a[7:0] ^ 8'h5A, a[7:0]} ^ {4{6'h00, k}};
   endfunction : mw

   task automatic cfg(input int a, input int b, input int c, input int d);
      pw = a[1:0];
      ps = b[1:0];
      sw = c[1:0];
      ss = d[1:0];
   endtask : cfg

   task automatic put(input logic [23:0] a, input logic wr, input logic f, input logic [31:0] wd);
      req_valid = 1'b1;
      req_addr = a;
      req_write = wr;
      req_fetch = f;
      req_wdata = wd;
      if (req_ready !== 1'b1) full = 1'b1;
      while (req_ready !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
   endtask : put

   task automatic xf(input logic [23:0] a, input logic wr, input logic f, input logic [31:0] wd,
      output logic [31:0] rd);
      int n0;
      n0 = rsp_n;
      put(a, wr, f, wd);
      req_valid = 1'b0;
      for (int i = 0; i < 200 && rsp_n == n0; i++) @(negedge clk_sys);
      chk("answer count", rsp_n - n0, 1);
      rd = rsp_d;
   endtask : xf

   // beats expected from group, width, size and item address
   task automatic ck(input string n, input logic [1:0] g, input int w, input int s, input logic [23:0] a,
      input logic wr, input logic [31:0] wd, input logic [31:0] rd);
      int nb, wb, nby, off;
      logic [25:0] b;
      logic [3:0] ln, p;
      logic [31:0] ex, m;
      nb = g == ESI_RG_NONE ? 0 : (s > w ? 1 << (s - w) : 1);
      wb = 1 << w;
      nby = 1 << (s < w ? s : w);
      m = 32'((64'h1 << (8 * nby)) - 1);
      ex = 32'h0;
      chk({n, " beats"}, bq.size(), nb);
      for (int k = 0; k < nb && k < bq.size(); k++) begin
         b = 26'(({2'h0, a} << s) + k * wb);
         off = b % wb;
         ln = 4'(((1 << nby) - 1) << off);
         p = w == 0 ? {b[1:0], 2'h2} : w == 1 ? {b[1], 1'b1, ~ln[1:0]} : ~ln;
         ex |= ((mw(b[25:2], g == ESI_RG_IO ? 2'h0 : p[3:2]) >> (8 * off)) & m) << (8 * k * nby);
         chk({n, " group"}, bq[k].g, g);
         chk({n, " addr"}, bq[k].a, b[25:2]);
         if (g != ESI_RG_IO) chk({n, " pins"}, bq[k].p, p);
         chk({n, " dir"}, bq[k].w, !wr);
         if (wr) chk({n, " wdata"}, (bq[k].d >> (8 * off)) & m, (wd >> (8 * k * nby)) & m);
      end
      chk({n, " rdata"}, rd, wr || nb == 0 ? 32'h0 : ex);
      bq.delete();
   endtask : ck

   task automatic t_rst;
      chk("reset pins", {pri_n, sec_n, io_n, wr_n, oe, rsp_valid, req_ready}, 13'h1FF9);
      chk("reset addr", mem_addr, 24'h0);
      chk("reset rdata", rsp_rdata, 32'h0);
      $display("reset test done");
   endtask : t_rst

   task automatic t_map;
      logic [23:0] at[14] = '{24'h000000, 24'h7FFFFF, 24'h800000, 24'h808000, 24'h80FFFF, 24'h810000,
         24'h82FFFF, 24'h830000, 24'h87FE00, 24'h87FFFF, 24'h880000, 24'h8FFFFF, 24'h900000, 24'hFFFFFF};
      logic [1:0] gt[14] = '{1, 1, 0, 0, 0, 3, 3, 0, 0, 0, 1, 1, 2, 2};
      logic [31:0] rd;
      // unused code 11 must act as 32 bits
      cfg(3, 3, 3, 3);
      foreach (at[i]) begin
         xf(at[i], 1'b0, 1'b0, 32'h0, rd);
         ck("map", gt[i], 2, 2, at[i], 1'b0, 32'h0, rd);
      end
      $display("map test done");
   endtask : t_map

   task automatic t_wid;
      logic [31:0] rd;
      logic [23:0] a;
      int ww, sz;
      for (int w = 0; w < 3; w++) for (int s = 0; s < 3; s++) for (int j = 0; j < 4; j++) begin
         cfg(w, s, 2 - w, 2 - s);
         a = j[0] ? 24'hA01235 : 24'h001237;
         ww = j[0] ? 2 - w : w;
         sz = j[0] ? 2 - s : s;
         xf(a, j[1], 1'b0, 32'h89ABCDEF, rd);
         ck("width", j[0] ? ESI_RG_SEC : ESI_RG_PRI, ww, sz, a, j[1], 32'h89ABCDEF, rd);
      end
      $display("width test done");
   endtask : t_wid

   task automatic t_fetch;
      logic [31:0] rd;
      // program words ignore the 8-bit item size
      cfg(2, 0, 2, 0);
      for (int i = 1; i >= 0; i--) begin
         pgm = i[0];
         repeat (4) @(negedge clk_sys);
         xf(24'h000104, 1'b0, 1'b1, 32'h0, rd);
         ck("fetch", ESI_RG_PRI, i ? 1 : 2, 2, 24'h000104, 1'b0, 32'h0, rd);
      end
      $display("fetch test done");
   endtask : t_fetch

   task automatic t_fifo;
      int n0;
      n0 = rsp_n;
      full = 1'b0;
      // set widths at 8 bits: the I/O strobe must ignore them
      cfg(0, 0, 0, 0);
      for (int i = 0; i < 20; i++) put(24'h810000 + i, 1'b1, 1'b0, i);
      req_valid = 1'b0;
      for (int i = 0; i < 1000 && rsp_n - n0 < 20; i++) @(negedge clk_sys);
      chk("queue refused", full, 1'b1);
      chk("queue answers", rsp_n - n0, 20);
      chk("queue drained", req_ready, 1'b1);
      chk("io beats", bq.size(), 20);
      for (int i = 0; i < 20 && i < bq.size(); i++) chk("io order", bq[i].a, 24'h810000 + i);
      bq.delete();
      $display("queue test done");
   endtask : t_fifo

   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_addr = 24'h0;
      req_write = 1'b0;
      req_fetch = 1'b0;
      req_wdata = 32'h0;
      pgm = 1'b0;
      full = 1'b0;
      cfg(2, 2, 2, 2);
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      t_rst;
      t_map;
      t_wid;
      t_fetch;
      t_fifo;
      close_out;
   end

   initial begin
      #(20000 * 4);
      miscompares++;
      close_out;
   end
endmodule : esi_strobe_engine_bench
